// ### rtl/hmu_pkg.sv
package hmu_pkg;
    // instruction field positions
    localparam int OPC_LSB = 0;
    localparam int RD_LSB = 7;
    localparam int F3_LSB = 12;
    localparam int RS_SHIFT_LSB = 25;
    localparam int F7_LSB = 25;
    localparam int VSEL_LSB = 30;
    // opcode and function codes
    localparam logic [6:0] OPC_HALF = 7'h5B;
    localparam logic [6:0] OPC_WORD = 7'h2B;
    localparam logic [2:0] F3_UMUL = 3'h5;
    localparam logic [2:0] F3_SMUL = 3'h4;
    localparam logic [2:0] F3_UMAC = 3'h7;
    localparam logic [2:0] F3_SMAC = 3'h6;
    localparam logic [2:0] F3_WORD = 3'h3;
    localparam logic [6:0] F7_MAC = 7'h48;
    localparam logic [6:0] F7_MSU = 7'h49;
    // variant select codes
    localparam logic [1:0] VSEL_LOW = 2'h0;
    localparam logic [1:0] VSEL_HIGH = 2'h1;
    localparam logic [1:0] VSEL_RLOW = 2'h2;
    localparam logic [1:0] VSEL_RHIGH = 2'h3;
    // reset values of the result port
    localparam logic [31:0] RST_DATA = 32'h0000_0000;
    localparam logic [4:0] RST_DEST = 5'h00;
endpackage

// ### rtl/hmu_unit.sv
// Operation
// - the custom multiply and accumulate operations exist only when pulp_ext_enable is 1.
// - unsigned low multiply zero-extends both low halves, multiplies, shifts right logically.
// - high variants use bits 31:16 of both sources, otherwise as the low variant.
// - signed variants sign-extend the halves and shift the product arithmetically.
// - rounding variants add two to the shift minus one first, zero when shift is 0.
// - plain forms are the shifting forms with shift 0, giving the full product.
// - half accumulate adds the destination value before the shift and writes it back.
// - signed accumulate sign-extends and shifts arithmetically, unsigned uses zero and logical.
// - rounding accumulate adds destination and rounding addend before the shift.
// - half forms use opcode 101 1011, shift in bits 29:25, variant in bits 31:30.
// - funct3 101 is unsigned multiply, 100 signed multiply.
// - funct3 111 is unsigned accumulate, 110 signed accumulate.
// - word forms use opcode 010 1011, funct3 011, funct7 100 1000 add, 100 1001 subtract.
`timescale 1ns/10ps
`default_nettype none
module hmu_unit #(
    parameter int pulp_ext_enable = 1
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] rs1_val,
    input wire logic [31:0] rs2_val,
    input wire logic [31:0] rd_val,
    output logic res_valid,
    output logic res_illegal,
    output logic [31:0] res_data,
    output logic [4:0] res_dest
);
    // field extraction
    logic [6:0] opcode;
    logic [2:0] funct3;
    logic [6:0] funct7;
    logic [1:0] variant_select_field;
    logic [4:0] shift_imm;
    logic [4:0] dest;
    assign opcode = instr[hmu_pkg::OPC_LSB +: 7];
    assign funct3 = instr[hmu_pkg::F3_LSB +: 3];
    assign funct7 = instr[hmu_pkg::F7_LSB +: 7];
    assign variant_select_field = instr[hmu_pkg::VSEL_LSB +: 2];
    assign shift_imm = instr[hmu_pkg::RS_SHIFT_LSB +: 5];
    assign dest = instr[hmu_pkg::RD_LSB +: 5];

    // decode of the two families; disabled builds recognise nothing
    function automatic logic hmu_is_half(input logic [31:0] i);
        hmu_is_half = (i[hmu_pkg::OPC_LSB +: 7] == hmu_pkg::OPC_HALF) &&
            i[hmu_pkg::F3_LSB + 2];
    endfunction
    function automatic logic hmu_is_word(input logic [31:0] i);
        hmu_is_word = (i[hmu_pkg::OPC_LSB +: 7] == hmu_pkg::OPC_WORD) &&
            (i[hmu_pkg::F3_LSB +: 3] == hmu_pkg::F3_WORD) &&
            ((i[hmu_pkg::F7_LSB +: 7] == hmu_pkg::F7_MAC) ||
             (i[hmu_pkg::F7_LSB +: 7] == hmu_pkg::F7_MSU));
    endfunction
    logic ext_on;
    logic is_half;
    logic is_word;
    logic known;
    assign ext_on = (pulp_ext_enable == 1);
    assign is_half = ext_on && hmu_is_half(instr);
    assign is_word = ext_on && hmu_is_word(instr);
    assign known = is_half || is_word;

    // variant bits: funct3 bit0 low means signed, bit1 means accumulate
    logic is_signed;
    logic is_mac;
    logic use_high;
    logic use_round;
    assign is_signed = ~funct3[0];
    assign is_mac = funct3[1];
    assign use_high = variant_select_field[0];
    assign use_round = variant_select_field[1];

    // half-word operand select and extension to 17 bits
    logic [15:0] half_a;
    logic [15:0] half_b;
    logic signed [16:0] ext_a;
    logic signed [16:0] ext_b;
    assign half_a = use_high ? rs1_val[31:16] : rs1_val[15:0];
    assign half_b = use_high ? rs2_val[31:16] : rs2_val[15:0];
    assign ext_a = {is_signed & half_a[15], half_a};
    assign ext_b = {is_signed & half_b[15], half_b};

    // 35 bits hold product plus destination plus addend without loss
    logic signed [33:0] half_prod;
    logic signed [34:0] acc_ext;
    logic signed [34:0] round_add;
    logic signed [34:0] half_sum;
    logic signed [34:0] half_shift;
    assign half_prod = ext_a * ext_b;
    assign acc_ext = is_mac ? {{3{is_signed & rd_val[31]}}, rd_val} : 35'h0;
    assign round_add = (use_round && (shift_imm != 5'h00)) ?
        (35'h1 << (shift_imm - 5'h01)) : 35'h0;
    assign half_sum = {half_prod[33], half_prod} + acc_ext + round_add;
    // unsigned sums are never negative, so one arithmetic shift serves both kinds
    assign half_shift = half_sum >>> shift_imm;

    // full-word forms wrap modulo 2^32
    logic [63:0] word_full;
    logic [31:0] word_res;
    assign word_full = rs1_val * rs2_val;
    assign word_res = (funct7 == hmu_pkg::F7_MSU) ?
        (rd_val - word_full[31:0]) : (rd_val + word_full[31:0]);

    logic [31:0] next_data;
    assign next_data = is_word ? word_res :
        (is_half ? half_shift[31:0] : hmu_pkg::RST_DATA);

    // one result per accepted instruction, registered one cycle later
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            res_valid <= 1'b0;
            res_illegal <= 1'b0;
            res_data <= hmu_pkg::RST_DATA;
            res_dest <= hmu_pkg::RST_DEST;
        end
        else
        begin
            res_valid <= in_valid && known;
            res_illegal <= in_valid && !known;
            res_data <= in_valid ? next_data : res_data;
            res_dest <= in_valid ? dest : res_dest;
        end
    end

    // independent 64-bit reference values for the checks below
    logic signed [63:0] s1_lo;
    logic signed [63:0] s2_lo;
    logic signed [63:0] s1_hi;
    logic signed [63:0] s2_hi;
    logic signed [63:0] rd_s;
    logic [63:0] rnd;
    logic [63:0] ref_umul_lo;
    logic [63:0] ref_umul_lo_r;
    logic [63:0] ref_umac_lo;
    logic [63:0] ref_umac_hi_r;
    logic signed [63:0] ref_smul_lo;
    logic signed [63:0] ref_smul_hi;
    logic signed [63:0] ref_smac_hi;
    logic [63:0] ref_umul_hi;
    logic signed [63:0] ref_smul_hi_r;
    logic signed [63:0] ref_smac_lo;
    assign s1_lo = {{48{rs1_val[15]}}, rs1_val[15:0]};
    assign s2_lo = {{48{rs2_val[15]}}, rs2_val[15:0]};
    assign s1_hi = {{48{rs1_val[31]}}, rs1_val[31:16]};
    assign s2_hi = {{48{rs2_val[31]}}, rs2_val[31:16]};
    assign rd_s = {{32{rd_val[31]}}, rd_val};
    assign rnd = (shift_imm == 5'h00) ? 64'h0 : (64'h1 << (shift_imm - 5'h01));
    assign ref_umul_lo = ({48'h0, rs1_val[15:0]} * {48'h0, rs2_val[15:0]}) >> shift_imm;
    assign ref_umul_lo_r = ({48'h0, rs1_val[15:0]} * {48'h0, rs2_val[15:0]} + rnd)
        >> shift_imm;
    assign ref_umac_lo = ({48'h0, rs1_val[15:0]} * {48'h0, rs2_val[15:0]} +
        {32'h0, rd_val}) >> shift_imm;
    assign ref_umac_hi_r = ({48'h0, rs1_val[31:16]} * {48'h0, rs2_val[31:16]} +
        {32'h0, rd_val} + rnd) >> shift_imm;
    assign ref_smul_lo = (s1_lo * s2_lo) >>> shift_imm;
    assign ref_smul_hi = (s1_hi * s2_hi) >>> shift_imm;
    assign ref_smac_hi = (s1_hi * s2_hi + rd_s) >>> shift_imm;
    // rounding addend cast signed so the shift stays arithmetic for negative products
    assign ref_umul_hi = ({48'h0, rs1_val[31:16]} * {48'h0, rs2_val[31:16]}) >> shift_imm;
    assign ref_smul_hi_r = (s1_hi * s2_hi + $signed(rnd)) >>> shift_imm;
    assign ref_smac_lo = (s1_lo * s2_lo + rd_s) >>> shift_imm;

    logic half_go;
    logic word_go;
    assign half_go = in_valid && ext_on && (opcode == hmu_pkg::OPC_HALF);
    assign word_go = in_valid && is_word;

    a_ext_gate: assert property (
        @(posedge mclk) disable iff (srst)
        (in_valid && hmu_is_half(instr)) |=> (res_valid == (pulp_ext_enable == 1)))
        else $error("half op accepted against build option");

    a_umul_low: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_UMUL && variant_select_field == hmu_pkg::VSEL_LOW)
        |=> (res_valid && res_data == $past(ref_umul_lo[31:0])))
        else $error("unsigned low multiply wrong");

    a_high_half: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_SMUL && variant_select_field == hmu_pkg::VSEL_HIGH)
        |=> (res_data == $past(ref_smul_hi[31:0])))
        else $error("signed high multiply wrong");

    a_signed_low: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_SMUL && variant_select_field == hmu_pkg::VSEL_LOW)
        |=> (res_data == $past(ref_smul_lo[31:0])))
        else $error("signed low multiply wrong");

    a_round_mul: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_UMUL && variant_select_field == hmu_pkg::VSEL_RLOW)
        |=> (res_data == $past(ref_umul_lo_r[31:0])))
        else $error("rounded multiply wrong");

    a_plain_full: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_UMUL && shift_imm == 5'h00 &&
         variant_select_field == hmu_pkg::VSEL_LOW)
        |=> (res_data == {16'h0000, $past(rs1_val[15:0])} * {16'h0000, $past(rs2_val[15:0])}))
        else $error("plain multiply not full product");

    a_umac_low: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_UMAC && variant_select_field == hmu_pkg::VSEL_LOW)
        |=> (res_data == $past(ref_umac_lo[31:0])))
        else $error("unsigned accumulate wrong");

    a_smac_high: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_SMAC && variant_select_field == hmu_pkg::VSEL_HIGH)
        |=> (res_data == $past(ref_smac_hi[31:0])))
        else $error("signed high accumulate wrong");

    a_round_mac: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_UMAC && variant_select_field == hmu_pkg::VSEL_RHIGH)
        |=> (res_data == $past(ref_umac_hi_r[31:0])))
        else $error("rounded accumulate wrong");

    a_word_mac: assert property (
        @(posedge mclk) disable iff (srst)
        (word_go && funct7 == hmu_pkg::F7_MAC)
        |=> (res_data == $past(rd_val) + $past(rs1_val) * $past(rs2_val)))
        else $error("word accumulate wrong");

    a_word_msu: assert property (
        @(posedge mclk) disable iff (srst)
        (word_go && funct7 == hmu_pkg::F7_MSU)
        |=> (res_data == $past(rd_val) - $past(rs1_val) * $past(rs2_val)))
        else $error("word subtract wrong");

    a_dest_index: assert property (
        @(posedge mclk) disable iff (srst)
        (in_valid && known) |=> (res_valid && res_dest == $past(dest)))
        else $error("destination index lost");

    a_half_class: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3[2]) |=> (res_valid && !res_illegal))
        else $error("half funct3 not accepted");

    a_word_class: assert property (
        @(posedge mclk) disable iff (srst)
        (in_valid && opcode == hmu_pkg::OPC_WORD && funct3 == hmu_pkg::F3_WORD &&
         funct7 != hmu_pkg::F7_MAC && funct7 != hmu_pkg::F7_MSU) |=> res_illegal)
        else $error("foreign word op accepted");

    a_wide_sum: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_UMAC && variant_select_field == hmu_pkg::VSEL_LOW &&
         shift_imm == 5'h01 && rd_val == 32'hFFFF_FFFF && rs1_val[15:0] == 16'hFFFF &&
         rs2_val[15:0] == 16'hFFFF) |=> res_data[31])
        else $error("carry lost before shift");

    a_word_gate: assert property (
        @(posedge mclk) disable iff (srst)
        (in_valid && hmu_is_word(instr)) |=> (res_valid == (pulp_ext_enable == 1)))
        else $error("word op accepted against build option");

    a_umul_high: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_UMUL && variant_select_field == hmu_pkg::VSEL_HIGH)
        |=> (res_valid && res_data == $past(ref_umul_hi[31:0])))
        else $error("unsigned high multiply wrong");

    a_round_zero: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_SMUL && variant_select_field == hmu_pkg::VSEL_RLOW &&
         shift_imm == 5'h00) |=> (res_data == $past(ref_smul_lo[31:0])))
        else $error("rounding addend not zero at shift 0");

    a_smul_round: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_SMUL && variant_select_field == hmu_pkg::VSEL_RHIGH)
        |=> (res_data == $past(ref_smul_hi_r[31:0])))
        else $error("signed rounded high multiply wrong");

    a_smac_low: assert property (
        @(posedge mclk) disable iff (srst)
        (half_go && funct3 == hmu_pkg::F3_SMAC && variant_select_field == hmu_pkg::VSEL_LOW)
        |=> (res_valid && res_data == $past(ref_smac_lo[31:0])))
        else $error("signed low accumulate wrong");

    a_one_answer: assert property (
        @(posedge mclk) disable iff (srst)
        in_valid |=> (res_valid != res_illegal))
        else $error("instruction without exactly one answer");

    a_idle_quiet: assert property (
        @(posedge mclk) disable iff (srst)
        (!in_valid) |=> (!res_valid && !res_illegal && $stable(res_data) && $stable(res_dest)))
        else $error("result changed with no instruction");
endmodule
`default_nettype wire

// ### test/hmu_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// issue stage that registers the operand values in front of the unit
module hmu_core_model (
    input wire logic mclk,
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_instr,
    input wire logic [31:0] cmd_rs1,
    input wire logic [31:0] cmd_rs2,
    input wire logic [31:0] cmd_rd,
    output logic in_valid,
    output logic [31:0] instr,
    output logic [31:0] rs1_val,
    output logic [31:0] rs2_val,
    output logic [31:0] rd_val
);
    // known idle values at time zero
    initial
    begin
        in_valid = 1'b0;
        {instr, rs1_val, rs2_val, rd_val} = {4{32'hA5A5_5A5A}};
    end
    // idle cycles invert the lines so a stale value never passes for fresh
    always @(posedge mclk)
    begin
        in_valid <= cmd_valid;
        if (cmd_valid)
        begin
            instr <= cmd_instr;
            rs1_val <= cmd_rs1;
            rs2_val <= cmd_rs2;
            rd_val <= cmd_rd;
        end
        else
        begin
            {instr, rs1_val, rs2_val, rd_val} <= ~{instr, rs1_val, rs2_val, rd_val};
        end
    end
endmodule
`default_nettype wire

// ### test/hmu_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module hmu_unit_tb_top;
    logic mclk, srst, cv, iv, rv, ri, ov, oi;
    logic [31:0] ci, c1, c2, cd, ins, a1, a2, ad, rdat, odat;
    logic [4:0] rdst, sh;
    logic [37:0] e;
    logic [37:0] exp_q[$];
    int num_errors = 0, n_checks = 0, cycles = 0, seed = 32'h42A7;
    hmu_core_model hmu_core_model_inst (.mclk(mclk), .cmd_valid(cv), .cmd_instr(ci),
        .cmd_rs1(c1), .cmd_rs2(c2), .cmd_rd(cd), .in_valid(iv), .instr(ins),
        .rs1_val(a1), .rs2_val(a2), .rd_val(ad));
    hmu_unit hmu_unit_inst (.mclk(mclk), .srst(srst), .in_valid(iv), .instr(ins),
        .rs1_val(a1), .rs2_val(a2), .rd_val(ad), .res_valid(rv), .res_illegal(ri),
        .res_data(rdat), .res_dest(rdst));
    // same traffic into a build without the extension
    hmu_unit #(.pulp_ext_enable(0)) hmu_unit_off_inst (.mclk(mclk), .srst(srst),
        .in_valid(iv), .instr(ins), .rs1_val(a1), .rs2_val(a2), .rd_val(ad),
        .res_valid(ov), .res_illegal(oi), .res_data(odat), .res_dest());
    // reference result: {illegal, dest, data}; the sum is kept in 64 bits so it is exact
    function automatic logic [37:0] predict(logic [31:0] i, r1, r2, d);
        logic [15:0] h1, h2;
        logic sg;
        longint s;
        h1 = i[30] ? r1[31:16] : r1[15:0];
        h2 = i[30] ? r2[31:16] : r2[15:0];
        sg = ~i[12];
        if (i[6:0] == 7'h2B && i[14:12] == 3'h3 && i[31:26] == 6'h24)
            return {1'b0, i[11:7], i[25] ? d - r1 * r2 : d + r1 * r2};
        if (i[6:0] != 7'h5B || !i[14])
            return {1'b1, i[11:7], 32'h0};
        s = sg ? longint'($signed(h1)) * longint'($signed(h2)) : longint'(h1) * longint'(h2);
        if (i[13])
            s = s + (sg ? longint'($signed(d)) : longint'(d));
        if (i[31] && i[29:25] != 5'h0)
            s = s + (longint'(1) << (i[29:25] - 1));
        s = s >>> i[29:25];
        return {1'b0, i[11:7], s[31:0]};
    endfunction
    // one instruction per call, back to back when called in a row
    task automatic issue(logic [31:0] i, r1, r2, d);
        cv <= 1'b1;
        ci <= i;
        c1 <= r1;
        c2 <= r2;
        cd <= d;
        exp_q.push_back(predict(i, r1, r2, d));
        @(posedge mclk);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // watcher: every result of the enabled build retires the oldest note; also the hang limit
    always @(posedge mclk)
    begin
        cycles++;
        if (rv === 1'b1 || ri === 1'b1)
        begin
            `CHK(exp_q.size() != 0, 1'b1)
            e = exp_q.pop_front();
            `CHK({ri, rv}, {e[37], ~e[37]})
            `CHK(rdst, e[36:32])
            `CHK(rdat, e[31:0])
        end
        if (ov === 1'b1 || oi === 1'b1)
            `CHK({oi, ov, odat}, {2'b10, 32'h0})
        if (cycles == 2000)
        begin
            num_errors++;
            test_done();
        end
    end
    initial
    begin
        {srst, cv, ci, c1, c2, cd} = {2'b10, 128'h0};
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        // all half-word variants at shift 0, 1, 31 and random, plus corner operands
        for (int f = 0; f < 16; f++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                sh = (k == 0) ? 5'h0 : (k == 1) ? 5'h1 : (k == 2) ? 5'h1F : 5'($random(seed));
                issue({f[3:2], sh, 10'($random(seed)), 1'b1, f[1:0], 5'($random(seed)), 7'h5B},
                    $random(seed), $random(seed), $random(seed));
            end
            issue({f[3:2], 5'h1, 10'h0, 1'b1, f[1:0], 5'h1F, 7'h5B},
                32'h8000_7FFF, 32'h8000_8000, 32'h7FFF_FFFF);
        end
        issue({2'h0, 5'h1, 10'h0, 3'h7, 5'h2, 7'h5B}, 32'hFFFF, 32'hFFFF, 32'hFFFF_FFFF);
        $display("test half-word done");
        // word accumulate and subtract with wrap-around
        for (int j = 0; j < 8; j++)
            issue({6'h24, j[0], 10'($random(seed)), 3'h3, 5'($random(seed)), 7'h2B},
                $random(seed), $random(seed), $random(seed));
        $display("test word done");
        // encodings outside the block, four in a row with no legal ones among them
        issue({25'($random(seed)), 7'h33}, 32'h1, 32'h2, 32'h3);
        issue({17'($random(seed)), 3'h2, 5'h3, 7'h5B}, 32'h1, 32'h2, 32'h3);
        issue({7'h28, 10'h0, 3'h3, 5'h4, 7'h2B}, 32'h5, 32'h6, 32'h7);
        issue({7'h48, 10'h0, 3'h2, 5'h5, 7'h2B}, 32'h5, 32'h6, 32'h7);
        cv <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(exp_q.size(), 0)
        $display("test illegal done");
        // reset in mid-run clears the result port
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        `CHK({rv, ri, rdst, rdat}, 39'h0)
        @(posedge mclk);
        srst <= 1'b0;
        issue({2'h2, 5'h3, 10'h0, 3'h7, 5'h9, 7'h5B}, 32'hFFFF, 32'hFFFF, 32'hFFFF_FFFF);
        cv <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(exp_q.size(), 0)
        $display("test reset done");
        test_done();
    end
endmodule
`default_nettype wire
